// ==== inc/timer_pkg.sv ====
package timer_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned CNT_W  = 16;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_COUNT  = 8'h04;
  localparam logic [7:0] OFF_PERIOD = 8'h08;
  localparam logic [7:0] OFF_FLAG   = 8'h0C;
  localparam logic [7:0] OFF_IRQEN  = 8'h10;
  localparam logic [7:0] OFF_OSC    = 8'h14;

  // Reset values
  localparam logic [15:0] CTRL_RST   = 16'h0000;
  localparam logic [15:0] COUNT_RST  = 16'h0000;
  localparam logic [15:0] PERIOD_RST = 16'hFFFF;

  // Writable bits of the control word
  localparam logic [15:0] CTRL_WMASK = 16'hA076;

  // Bit positions of single-bit registers
  localparam int unsigned FLAG_BIT  = 0;
  localparam int unsigned IRQEN_BIT = 0;
  localparam int unsigned LPOSC_BIT = 1;

  // Instruction cycle is the system clock divided by four
  localparam int unsigned INSTR_DIV = 4;
  localparam int unsigned DIV_W     = 2;

  // Prescale ratio codes
  localparam logic [1:0] PS_1   = 2'h0;
  localparam logic [1:0] PS_8   = 2'h1;
  localparam logic [1:0] PS_64  = 2'h2;
  localparam logic [1:0] PS_256 = 2'h3;
  localparam int unsigned PS_W  = 8;

  typedef struct packed {
    logic       timer_on;
    logic       rsv14;
    logic       stop_in_idle;
    logic [5:0] rsv12_7;
    logic       gate_accum_enable;
    logic [1:0] prescale_select;
    logic       rsv3;
    logic       ext_clock_sync;
    logic       clock_source_select;
    logic       rsv0;
  } ctrl_t;

  typedef struct packed {
    logic level;
    logic rise;
    logic fall;
  } edge_t;
endpackage

// ==== hw/edge_sync.sv ====
module edge_sync (
  input  wire logic           clk,
  input  wire logic           rst_n,
  input  wire logic           pin_in,
  output timer_pkg::edge_t    edges
);
  logic meta_reg;
  logic sync_reg;
  logic last_reg;

  // Two-stage synchroniser, then a history flop for edges
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  assign edges.level = sync_reg;
  assign edges.rise  = sync_reg & ~last_reg;
  assign edges.fall  = ~sync_reg & last_reg;
endmodule

// ==== hw/prescaler.sv ====
module prescaler #(
  parameter int unsigned W = timer_pkg::PS_W
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       tick_in,
  input  wire logic       clear,
  input  wire logic [1:0] ratio,
  output logic            tick_out
);
  logic [W-1:0] cnt_reg;
  logic [W-1:0] limit;

  function automatic logic [W-1:0] ratio_limit(input logic [1:0] r);
    case (r)
      timer_pkg::PS_1:   ratio_limit = W'(0);
      timer_pkg::PS_8:   ratio_limit = W'(7);
      timer_pkg::PS_64:  ratio_limit = W'(63);
      timer_pkg::PS_256: ratio_limit = W'(255);
      default:           ratio_limit = W'(0);
    endcase
  endfunction

  assign limit    = ratio_limit(ratio);
  assign tick_out = tick_in & (cnt_reg >= limit);

  // Counts only on input ticks; a clear takes effect even with the source halted
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= '0;
    end else if (clear) begin
      cnt_reg <= '0;
    end else if (tick_in) begin
      cnt_reg <= tick_out ? '0 : W'(cnt_reg + 1'b1);
    end
  end
endmodule

// ==== hw/gated_timer.sv ====
// Overview of operation
// - Gate mode counts instruction cycles while gate high
// - Gate mode needs timer on, internal clock
// - Idle stops counting when stop_in_idle set
// - Source is instruction clock or external clock
// - Prescaler divides by 1, 8, 64, 256
// - Prescaler cleared on count write, off, reset
// - Prescaler halted while timer off
// - Control write leaves count untouched
// - Sleep counting needs on, external, and asynchronous or oscillator mode
// - Count to period, then restart at zero
// - Match sets sticky flag; enable gates interrupt
// - Gate falling edge also sets flag
// - Oscillator mode counts low-power oscillator rising edges
// - Oscillator enable overrides modes, adds carry wake-up
// - Oscillator mode keeps counting through Sleep with external source selected
// - Interrupt forwarded only while enable set
//
// Local design decisions: the register offsets and the APB interface to the registers.
module gated_timer #(
  parameter int unsigned CW = timer_pkg::CNT_W
) (
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [timer_pkg::ADDR_W-1:0] paddr,
  input  wire logic [timer_pkg::DATA_W-1:0] pwdata,
  output logic      [timer_pkg::DATA_W-1:0] prdata,
  output logic                              pready,
  output logic                              pslverr,
  input  wire logic                         gate_input_pin,
  input  wire logic                         lp_osc_in,
  input  wire logic                         cpu_idle,
  input  wire logic                         cpu_sleep,
  output logic                              timer_irq,
  output logic                              wake_event
);
  timer_pkg::ctrl_t ctrl_reg;
  logic [CW-1:0]    count_reg;
  logic [CW-1:0]    count_next;
  logic [CW-1:0]    period_reg;
  logic             flag_reg;
  logic             flag_next;
  logic             irq_en_reg;
  logic             lposc_reg;
  logic [timer_pkg::DIV_W-1:0] div_reg;
  logic [timer_pkg::DATA_W-1:0] prdata_reg;
  logic             pready_reg;
  logic             pslverr_reg;
  logic             irq_reg;
  logic             wake_reg;

  timer_pkg::edge_t gate_e;
  timer_pkg::edge_t osc_e;

  logic access;
  logic done;
  logic mapped;
  logic wr_ctrl;
  logic wr_count;
  logic wr_period;
  logic wr_flag;
  logic wr_irqen;
  logic wr_osc;
  logic instr_tick;
  logic gate_mode;
  logic idle_hold;
  logic sleep_ok;
  logic run;
  logic src_tick;
  logic ps_clear;
  logic ps_tick;
  logic at_period;
  logic match_evt;
  logic gate_end;
  logic turn_off;
  logic count_clear;
  logic sleep_hold;
  logic ps_in;

  function automatic logic is_mapped(input logic [timer_pkg::ADDR_W-1:0] a);
    case (a)
      timer_pkg::OFF_CTRL,
      timer_pkg::OFF_COUNT,
      timer_pkg::OFF_PERIOD,
      timer_pkg::OFF_FLAG,
      timer_pkg::OFF_IRQEN,
      timer_pkg::OFF_OSC: is_mapped = 1'b1;
      default:            is_mapped = 1'b0;
    endcase
  endfunction

  function automatic logic [timer_pkg::DATA_W-1:0] read_mux(
    input logic [timer_pkg::ADDR_W-1:0] a,
    input timer_pkg::ctrl_t c,
    input logic [CW-1:0] cnt,
    input logic [CW-1:0] per,
    input logic fl,
    input logic ie,
    input logic lp
  );
    read_mux = '0;
    case (a)
      timer_pkg::OFF_CTRL:   read_mux[15:0] = c;
      timer_pkg::OFF_COUNT:  read_mux[CW-1:0] = cnt;
      timer_pkg::OFF_PERIOD: read_mux[CW-1:0] = per;
      timer_pkg::OFF_FLAG:   read_mux[timer_pkg::FLAG_BIT] = fl;
      timer_pkg::OFF_IRQEN:  read_mux[timer_pkg::IRQEN_BIT] = ie;
      timer_pkg::OFF_OSC:    read_mux[timer_pkg::LPOSC_BIT] = lp;
      default:               read_mux = '0;
    endcase
  endfunction

  // Pin inputs pass a two-flop synchroniser
  edge_sync u_gate_sync (
    .clk    (pclk),
    .rst_n  (presetn),
    .pin_in (gate_input_pin),
    .edges  (gate_e)
  );

  edge_sync u_osc_sync (
    .clk    (pclk),
    .rst_n  (presetn),
    .pin_in (lp_osc_in),
    .edges  (osc_e)
  );

  // APB decode: one wait state, answer in the second access cycle
  assign access = psel & penable;
  assign done   = access & pready_reg;
  assign mapped = is_mapped(paddr);

  // Write strobes, one per register, on the completing access
  always_comb begin
    wr_ctrl   = 1'b0;
    wr_count  = 1'b0;
    wr_period = 1'b0;
    wr_flag   = 1'b0;
    wr_irqen  = 1'b0;
    wr_osc    = 1'b0;
    if (done & pwrite) begin
      case (paddr)
        timer_pkg::OFF_CTRL:   wr_ctrl   = 1'b1;
        timer_pkg::OFF_COUNT:  wr_count  = 1'b1;
        timer_pkg::OFF_PERIOD: wr_period = 1'b1;
        timer_pkg::OFF_FLAG:   wr_flag   = 1'b1;
        timer_pkg::OFF_IRQEN:  wr_irqen  = 1'b1;
        timer_pkg::OFF_OSC:    wr_osc    = 1'b1;
        default:               wr_ctrl   = 1'b0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
    end else begin
      pready_reg <= access & ~pready_reg;
    end
  end

  // Read data stands only in the ready cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= '0;
    end else if (access & ~pready_reg & ~pwrite) begin
      prdata_reg <= read_mux(paddr, ctrl_reg, count_reg, period_reg,
                             flag_reg, irq_en_reg, lposc_reg);
    end else begin
      prdata_reg <= '0;
    end
  end

  // Error answer for addresses outside the map, only with ready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_reg <= 1'b0;
    end else if (access & ~pready_reg) begin
      pslverr_reg <= ~mapped;
    end else begin
      pslverr_reg <= 1'b0;
    end
  end

  // Control register; writing it never touches the count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= timer_pkg::CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_reg <= pwdata[15:0] & timer_pkg::CTRL_WMASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      period_reg <= timer_pkg::PERIOD_RST;
    end else if (wr_period) begin
      period_reg <= pwdata[CW-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en_reg <= 1'b0;
    end else if (wr_irqen) begin
      irq_en_reg <= pwdata[timer_pkg::IRQEN_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lposc_reg <= 1'b0;
    end else if (wr_osc) begin
      lposc_reg <= pwdata[timer_pkg::LPOSC_BIT];
    end
  end

  // Instruction cycle strobe from the system clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 1'b1;
    end
  end

  assign instr_tick = (div_reg == timer_pkg::DIV_W'(timer_pkg::INSTR_DIV - 1));

  // Gated accumulation only with internal source and no oscillator mode
  assign gate_mode = ctrl_reg.timer_on & ctrl_reg.gate_accum_enable
                   & ~ctrl_reg.clock_source_select & ~lposc_reg;

  assign idle_hold = cpu_idle & ctrl_reg.stop_in_idle;

  // Sleep keeps only external-source counting alive, when asynchronous or in oscillator mode
  assign sleep_ok = ctrl_reg.clock_source_select
                  & (~ctrl_reg.ext_clock_sync | lposc_reg);

  assign sleep_hold = cpu_sleep & ~sleep_ok;

  assign run = ctrl_reg.timer_on & ~idle_hold
             & ~sleep_hold;

  always_comb begin
    src_tick = 1'b0;
    if (lposc_reg) begin
      src_tick = osc_e.rise;
    end else if (ctrl_reg.clock_source_select) begin
      src_tick = gate_e.rise;
    end else if (ctrl_reg.gate_accum_enable) begin
      src_tick = instr_tick & gate_e.level;
    end else begin
      src_tick = instr_tick;
    end
  end

  assign turn_off = wr_ctrl & ctrl_reg.timer_on
                  & ~pwdata[$bits(timer_pkg::ctrl_t)-1];
  // A prescaler halted by timer off ignores count writes; switching off still clears it
  assign count_clear = wr_count & ctrl_reg.timer_on;
  assign ps_clear    = count_clear | turn_off;
  assign ps_in       = src_tick & run;

  // Prescaler between the selected source and the count
  prescaler #(
    .W (timer_pkg::PS_W)
  ) u_prescaler (
    .clk      (pclk),
    .rst_n    (presetn),
    .tick_in  (ps_in),
    .clear    (ps_clear),
    .ratio    (ctrl_reg.prescale_select),
    .tick_out (ps_tick)
  );

  assign at_period = (count_reg == period_reg);
  assign match_evt = ps_tick & at_period & ~wr_count;

  // Next count: software write first, then wrap at period
  always_comb begin
    count_next = count_reg;
    if (wr_count) begin
      count_next = pwdata[CW-1:0];
    end else if (ps_tick) begin
      count_next = at_period ? timer_pkg::COUNT_RST : CW'(count_reg + 1'b1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= timer_pkg::COUNT_RST;
    end else begin
      count_reg <= count_next;
    end
  end

  // Gate falling edge closes an accumulation cycle
  assign gate_end = gate_mode & gate_e.fall;

  // Sticky flag: a new event wins over a software clear
  always_comb begin
    flag_next = flag_reg;
    if (wr_flag & pwdata[timer_pkg::FLAG_BIT]) begin
      flag_next = 1'b0;
    end
    if (match_evt | gate_end) begin
      flag_next = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_reg <= 1'b0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  // Interrupt request gated by its enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= flag_next & irq_en_reg;
    end
  end

  // Carry-out wake-up pulse in oscillator mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_reg <= 1'b0;
    end else begin
      wake_reg <= match_evt & lposc_reg;
    end
  end

  assign prdata     = prdata_reg;
  assign pready     = pready_reg;
  assign pslverr    = pslverr_reg;
  assign timer_irq  = irq_reg;
  assign wake_event = wake_reg;
endmodule

// ==== tb/gated_timer_checker.sv ====
module gated_timer_checker #(
  parameter int unsigned CW = timer_pkg::CNT_W
) (
  input wire logic                         pclk,
  input wire logic                         presetn,
  input wire logic                         psel,
  input wire logic                         penable,
  input wire logic                         pwrite,
  input wire logic [timer_pkg::ADDR_W-1:0] paddr,
  input wire logic [timer_pkg::DATA_W-1:0] pwdata,
  input wire logic [timer_pkg::DATA_W-1:0] prdata,
  input wire logic                         pready,
  input wire logic                         pslverr,
  input wire logic                         gate_input_pin,
  input wire logic                         lp_osc_in,
  input wire logic                         cpu_idle,
  input wire logic                         cpu_sleep,
  input wire logic                         timer_irq,
  input wire logic                         wake_event
);
  logic unmapped;
  logic clr_wr;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  assign unmapped = (paddr[1:0] != 2'h0) || (paddr > timer_pkg::OFF_OSC);
  assign clr_wr = psel && pwrite && pready && (paddr == timer_pkg::OFF_FLAG || paddr == timer_pkg::OFF_IRQEN);
  a_ready_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready) else $error("late ready");
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready too long");
  a_err_decode: assert property (pready |-> pslverr == unmapped) else $error("bad decode");
  a_err_quiet: assert property (!pready |-> !pslverr) else $error("stray error");
  a_rdata_quiet: assert property (!pready |-> prdata == 32'h0) else $error("stray data");
  a_err_zero: assert property (pready && pslverr |-> prdata == 32'h0) else $error("error data");
  a_irq_sticky: assert property ($fell(timer_irq) |-> $past(clr_wr) || $past(clr_wr, 2)) else $error("irq dropped");
  a_wake_pulse: assert property (wake_event |=> !wake_event) else $error("wake too long");
  c_write: cover property (pready && pwrite);
  c_err: cover property (pslverr);
  c_irq: cover property ($rose(timer_irq));
  c_wake: cover property (wake_event);
endmodule

bind gated_timer gated_timer_checker #(.CW(CW)) i_gated_timer_checker (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .gate_input_pin(gate_input_pin), .lp_osc_in(lp_osc_in),
  .cpu_idle(cpu_idle), .cpu_sleep(cpu_sleep), .timer_irq(timer_irq), .wake_event(wake_event));

// ==== tb/timer_ext_source.sv ====
module timer_ext_source (
  input  wire logic pclk,
  input  wire logic gate_level,
  input  wire logic ext_run,
  input  wire logic osc_run,
  output logic      gate_input_pin,
  output logic      lp_osc_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] div = 5'h00;
  always @(posedge pclk) div <= div + 5'h01;
  // Gate level, or an external clock of 16 cycles that rests low
  assign gate_input_pin = gate_level | (ext_run & div[3]);
  // Oscillator of 32 cycles that stands still when stopped
  assign lp_osc_in = osc_run & div[4];
endmodule

// ==== tb/gated_timer_tb_top.sv ====
module gated_timer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, last_err;
  logic        gate_level, ext_run, osc_run, cpu_idle, cpu_sleep;
  logic        gate_input_pin, lp_osc_in, timer_irq, wake_event;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q, c;
  int          failures, checks_done;
  logic [7:0]  offs [6] = '{timer_pkg::OFF_CTRL, timer_pkg::OFF_COUNT, timer_pkg::OFF_PERIOD,
                            timer_pkg::OFF_FLAG, timer_pkg::OFF_IRQEN, timer_pkg::OFF_OSC};
  logic [31:0] rstv [6] = '{32'h0, 32'h0, 32'hFFFF, 32'h0, 32'h0, 32'h0};
  int          ratio [4] = '{1, 8, 64, 256};

  gated_timer i_gated_timer (.*);
  timer_ext_source i_timer_ext_source (.*);

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  task automatic end_sim;
    $display("checks %0d, mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi, input string m);
    checks_done++;
    if ($isunknown(got) || got < lo || got > hi) begin
      failures++;
      $display("unexpected at %0t: %s got %0h", $time, m, got);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 16) begin
      failures++;
      end_sim();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] lo, input logic [31:0] hi, input string m);
    apb(1'b0, a, 32'h0);
    chk(q, lo, hi, m);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic wait_hi(input logic w);
    int n;
    n = 0;
    while (((w ? wake_event : timer_irq) !== 1'b1) && n < 600) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 600) begin
      failures++;
      end_sim();
    end
  endtask

  task automatic note(input string s);
    $display("test %s finished, %0d checks", s, checks_done);
  endtask

  initial begin
    {psel, penable, pwrite, gate_level, ext_run, osc_run, cpu_idle, cpu_sleep} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    presetn = 1'b0;
    failures = 0;
    checks_done = 0;
    cyc(5);
    presetn <= 1'b1;
    foreach (offs[i]) rd(offs[i], rstv[i], rstv[i], "reset value");
    rd(8'h18, 32'h0, 32'h0, "unmapped data");
    chk(32'(last_err), 32'h1, 32'h1, "unmapped error");
    rd(8'h02, 32'h0, 32'h0, "unaligned data");
    chk(32'(last_err), 32'h1, 32'h1, "unaligned error");
    wr(timer_pkg::OFF_CTRL, 32'hFFFFFFFF);
    rd(timer_pkg::OFF_CTRL, {16'h0, timer_pkg::CTRL_WMASK}, {16'h0, timer_pkg::CTRL_WMASK}, "ctrl mask");
    wr(timer_pkg::OFF_CTRL, 32'h0);
    note("registers");
    wr(timer_pkg::OFF_PERIOD, 32'h5);
    wr(timer_pkg::OFF_COUNT, 32'h0);
    wr(timer_pkg::OFF_IRQEN, 32'h1);
    wr(timer_pkg::OFF_CTRL, 32'h8000);
    wait_hi(1'b0);
    wr(timer_pkg::OFF_CTRL, 32'h0);
    rd(timer_pkg::OFF_FLAG, 32'h1, 32'h1, "match flag");
    rd(timer_pkg::OFF_COUNT, 32'h0, 32'h5, "count wraps");
    c = q;
    wr(timer_pkg::OFF_FLAG, 32'h1);
    rd(timer_pkg::OFF_FLAG, 32'h0, 32'h0, "flag cleared");
    chk(32'(timer_irq), 32'h0, 32'h0, "irq cleared");
    wr(timer_pkg::OFF_CTRL, 32'h0010);
    rd(timer_pkg::OFF_COUNT, c, c, "ctrl write keeps count");
    note("match");
    for (int k = 0; k < 4; k++) begin
      wr(timer_pkg::OFF_COUNT, 32'h0);
      wr(timer_pkg::OFF_PERIOD, 32'hFFFF);
      wr(timer_pkg::OFF_CTRL, 32'h8000 | (k << 4));
      cyc(3072);
      wr(timer_pkg::OFF_CTRL, 32'h0);
      rd(timer_pkg::OFF_COUNT, 768 / ratio[k] - 1, 768 / ratio[k] + 2, "prescale");
    end
    note("prescale");
    wr(timer_pkg::OFF_COUNT, 32'h0);
    cpu_idle <= 1'b1;
    wr(timer_pkg::OFF_CTRL, 32'hA000);
    cyc(200);
    rd(timer_pkg::OFF_COUNT, 32'h0, 32'h0, "idle stops");
    cpu_idle <= 1'b0;
    cyc(100);
    rd(timer_pkg::OFF_COUNT, 32'd24, 32'd27, "idle resumes");
    cpu_idle <= 1'b1;
    wr(timer_pkg::OFF_COUNT, 32'h0);
    wr(timer_pkg::OFF_CTRL, 32'h8000);
    cyc(200);
    wr(timer_pkg::OFF_CTRL, 32'h0);
    cpu_idle <= 1'b0;
    rd(timer_pkg::OFF_COUNT, 32'd48, 32'd53, "idle runs");
    note("idle");
    wr(timer_pkg::OFF_IRQEN, 32'h0);
    wr(timer_pkg::OFF_COUNT, 32'h0);
    wr(timer_pkg::OFF_CTRL, 32'h8040);
    cyc(100);
    rd(timer_pkg::OFF_COUNT, 32'h0, 32'h0, "gate low holds");
    gate_level <= 1'b1;
    cyc(400);
    gate_level <= 1'b0;
    cyc(10);
    rd(timer_pkg::OFF_COUNT, 32'd97, 32'd102, "gated count");
    rd(timer_pkg::OFF_FLAG, 32'h1, 32'h1, "gate fall flag");
    chk(32'(timer_irq), 32'h0, 32'h0, "masked irq");
    note("gate");
    wr(timer_pkg::OFF_FLAG, 32'h1);
    wr(timer_pkg::OFF_COUNT, 32'h0);
    cpu_sleep <= 1'b1;
    wr(timer_pkg::OFF_CTRL, 32'h8000);
    cyc(200);
    rd(timer_pkg::OFF_COUNT, 32'h0, 32'h0, "sleep internal");
    wr(timer_pkg::OFF_CTRL, 32'h8002);
    ext_run <= 1'b1;
    cyc(320);
    ext_run <= 1'b0;
    rd(timer_pkg::OFF_COUNT, 32'd18, 32'd21, "sleep async");
    wr(timer_pkg::OFF_COUNT, 32'h0);
    wr(timer_pkg::OFF_CTRL, 32'h8006);
    ext_run <= 1'b1;
    cyc(320);
    ext_run <= 1'b0;
    rd(timer_pkg::OFF_COUNT, 32'h0, 32'h0, "sleep sync");
    cpu_sleep <= 1'b0;
    ext_run <= 1'b1;
    cyc(320);
    ext_run <= 1'b0;
    rd(timer_pkg::OFF_COUNT, 32'd18, 32'd21, "sync external");
    cpu_sleep <= 1'b1;
    note("sleep");
    wr(timer_pkg::OFF_COUNT, 32'h0);
    wr(timer_pkg::OFF_PERIOD, 32'h3);
    wr(timer_pkg::OFF_IRQEN, 32'h1);
    wr(timer_pkg::OFF_OSC, 32'h2);
    wr(timer_pkg::OFF_CTRL, 32'h8002);
    osc_run <= 1'b1;
    wait_hi(1'b1);
    chk(32'(timer_irq), 32'h1, 32'h1, "oscillator irq");
    osc_run <= 1'b0;
    wr(timer_pkg::OFF_COUNT, 32'h0);
    ext_run <= 1'b1;
    cyc(160);
    ext_run <= 1'b0;
    rd(timer_pkg::OFF_COUNT, 32'h0, 32'h0, "oscillator overrides");
    note("oscillator");
    end_sim();
  end
endmodule
